// ### sad_pkg.sv
package sad_pkg;

    // Address width of the flat system space.
    localparam int ADDR_W = 24;

    // Region bounds, inclusive.
    localparam logic [23:0] PFLASH_LO = 24'h000000;
    localparam logic [23:0] PFLASH_HI = 24'h03ffff;
    localparam logic [23:0] DFLASH_LO = 24'h0e0000;
    localparam logic [23:0] DFLASH_HI = 24'h0e1fff;
    localparam logic [23:0] RRAM_LO = 24'h0e8000;
    localparam logic [23:0] RRAM_HI = 24'h0e91ff;
    localparam logic [23:0] SRAM_LO = 24'h0ec000;
    localparam logic [23:0] SRAM_HI = 24'h0ee7ff;
    localparam logic [23:0] SEQRAM_LO = 24'h0ee800;
    localparam logic [23:0] SEQRAM_HI = 24'h0eebff;
    localparam logic [23:0] LINKREG_LO = 24'h0ef180;
    localparam logic [23:0] LINKREG_HI = 24'h0ef1ff;
    localparam logic [23:0] EXT1_LO = 24'h400000;
    localparam logic [23:0] EXT1_HI = 24'h7fffff;
    localparam logic [23:0] EXT2_LO = 24'h800000;
    localparam logic [23:0] EXT2_HI = 24'hfeffff;
    localparam logic [23:0] BUSPER_LO = 24'hff0000;
    localparam logic [23:0] BUSPER_HI = 24'hfffaff;
    localparam logic [23:0] IOZ_LO = 24'hfffb00;
    localparam logic [23:0] IOZ_HI = 24'hfffbff;
    localparam logic [23:0] PERIPH_LO = 24'hfffc00;
    localparam logic [23:0] PERIPH_HI = 24'hffffff;

    // Environment pin patterns.
    localparam logic [2:0] STRAP_DEVELOP = 3'h0;
    localparam logic [2:0] STRAP_EXT_ROM = 3'h3;
    localparam logic [2:0] STRAP_ISP = 3'h6;
    localparam logic [2:0] STRAP_INT_ROM = 3'h7;

    // Operating modes.
    typedef enum logic [1:0] {
        MODE_INT_ROM = 2'b00,
        MODE_EXT_ROM = 2'b01,
        MODE_DEVELOP = 2'b10,
        MODE_ISP = 2'b11
    } sad_mode_e;

    // Bus-interface zone that governs an access timing.
    typedef enum logic [2:0] {
        ZONE_NONE = 3'b000,
        ZONE_STATIC0 = 3'b001,
        ZONE_STATIC1 = 3'b010,
        ZONE_STATIC2 = 3'b011,
        ZONE_IO = 3'b100
    } sad_zone_e;

    // One-hot region selects.
    typedef struct packed {
        logic prog_flash;
        logic data_flash;
        logic radio_ram;
        logic system_ram;
        logic seq_ram;
        logic link_regs;
        logic ext_zone0;
        logic ext_zone1;
        logic ext_zone2;
        logic busif_periph;
        logic io_zone;
        logic periph;
    } sad_sel_s;

    // Core bus request.
    typedef struct packed {
        logic valid;
        logic write;
        logic [23:0] addr;
    } sad_req_s;

endpackage : sad_pkg

// ### sad_mode_latch.sv
`timescale 1ns/1ps
// Samples the environment pins through a two-stage synchroniser and
// freezes the operating mode at the third enabled edge after reset.
module sad_mode_latch (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Strap inputs.
    input wire logic [2:0] environment_select_pins,
    input wire logic flash_empty,
    // Mode result.
    output sad_pkg::sad_mode_e mode,
    output logic mode_valid
);

    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] next_sync1;
    logic [3:0] next_sync2;
    logic warm;
    logic next_warm;
    logic synced;
    logic next_synced;
    sad_pkg::sad_mode_e next_mode;
    logic next_mode_valid;

    // Mode is caught only after the synchroniser has filled, never at reset itself.
    always_comb begin
        next_sync1 = {environment_select_pins, flash_empty};
        next_sync2 = sync1;
        // The second stage holds a real pin sample only from the second edge on, so wait one more.
        next_warm = 1'b1;
        next_synced = warm;
        next_mode = mode;
        next_mode_valid = mode_valid;
        if (synced && !mode_valid) begin
            next_mode_valid = 1'b1;
            unique case (sync2[3:1])
                sad_pkg::STRAP_DEVELOP: next_mode = sad_pkg::MODE_DEVELOP;
                sad_pkg::STRAP_ISP: next_mode = sad_pkg::MODE_ISP;
                sad_pkg::STRAP_INT_ROM: next_mode = sync2[0] ? sad_pkg::MODE_ISP : sad_pkg::MODE_INT_ROM;
                sad_pkg::STRAP_EXT_ROM: next_mode = sync2[0] ? sad_pkg::MODE_ISP : sad_pkg::MODE_EXT_ROM;
                // Undefined patterns fall back to the pull-up default.
                default: next_mode = sad_pkg::MODE_INT_ROM;
            endcase
        end
    end

    // Registers only.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            warm <= 1'b0;
            synced <= 1'b0;
            mode <= sad_pkg::MODE_INT_ROM;
            mode_valid <= 1'b0;
        end else if (ce) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            warm <= next_warm;
            synced <= next_synced;
            mode <= next_mode;
            mode_valid <= next_mode_valid;
        end
    end

endmodule : sad_mode_latch

// ### sad_decoder.sv
`timescale 1ns/1ps
module sad_decoder (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Strap inputs.
    input wire logic [2:0] environment_select_pins,
    input wire logic flash_empty,
    // Core bus request.
    input sad_pkg::sad_req_s req,
    // Decoded outputs.
    output sad_pkg::sad_sel_s sel,
    output sad_pkg::sad_zone_e zone,
    output logic sel_valid,
    output logic sel_write,
    output logic [23:0] sel_addr,
    output logic reserved_hit,
    output sad_pkg::sad_mode_e mode,
    output logic mode_valid,
    output logic development_mode
);

    sad_pkg::sad_sel_s next_sel;
    sad_pkg::sad_zone_e next_zone;
    logic next_sel_valid;
    logic next_sel_write;
    logic [23:0] next_sel_addr;
    logic next_reserved_hit;
    logic in_pf;
    logic in_df;

    // Inclusive range test, used for every region.
    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Strap capture lives apart so its synchroniser stays isolated.
    sad_mode_latch u_mode (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .environment_select_pins(environment_select_pins),
        .flash_empty(flash_empty),
        .mode(mode),
        .mode_valid(mode_valid)
    );

    assign development_mode = (mode == sad_pkg::MODE_DEVELOP);

    // Decode one request; the whole 24-bit address is compared, no aliasing.
    always_comb begin
        next_sel = '0;
        next_zone = sad_pkg::ZONE_NONE;
        next_sel_write = req.write;
        next_sel_addr = req.addr;
        in_pf = in_range(req.addr, sad_pkg::PFLASH_LO, sad_pkg::PFLASH_HI);
        in_df = in_range(req.addr, sad_pkg::DFLASH_LO, sad_pkg::DFLASH_HI);
        if (in_pf || in_df) begin
            next_zone = sad_pkg::ZONE_STATIC0;
            if (development_mode) begin
                next_sel.ext_zone0 = 1'b1;
            end else begin
                next_sel.prog_flash = in_pf;
                next_sel.data_flash = in_df;
            end
        end
        next_sel.radio_ram = in_range(req.addr, sad_pkg::RRAM_LO, sad_pkg::RRAM_HI);
        next_sel.system_ram = in_range(req.addr, sad_pkg::SRAM_LO, sad_pkg::SRAM_HI);
        next_sel.seq_ram = in_range(req.addr, sad_pkg::SEQRAM_LO, sad_pkg::SEQRAM_HI);
        next_sel.link_regs = in_range(req.addr, sad_pkg::LINKREG_LO, sad_pkg::LINKREG_HI);
        if (in_range(req.addr, sad_pkg::EXT1_LO, sad_pkg::EXT1_HI)) begin
            next_sel.ext_zone1 = 1'b1;
            next_zone = sad_pkg::ZONE_STATIC1;
        end
        if (in_range(req.addr, sad_pkg::EXT2_LO, sad_pkg::EXT2_HI)) begin
            next_sel.ext_zone2 = 1'b1;
            next_zone = sad_pkg::ZONE_STATIC2;
        end
        next_sel.busif_periph = in_range(req.addr, sad_pkg::BUSPER_LO, sad_pkg::BUSPER_HI);
        if (in_range(req.addr, sad_pkg::IOZ_LO, sad_pkg::IOZ_HI)) begin
            next_sel.io_zone = 1'b1;
            next_zone = sad_pkg::ZONE_IO;
        end
        next_sel.periph = in_range(req.addr, sad_pkg::PERIPH_LO, sad_pkg::PERIPH_HI);
        // A reserved address is flagged but selects nothing; the master should never issue one.
        next_reserved_hit = req.valid && (next_sel == '0);
        // Requests before the mode is known are dropped, as flash routing is undefined then.
        next_sel_valid = req.valid && mode_valid;
        if (!next_sel_valid) begin
            next_sel = '0;
            next_zone = sad_pkg::ZONE_NONE;
        end
        if (!mode_valid) begin
            next_reserved_hit = 1'b0;
        end
    end

    // Output registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel <= '0;
            zone <= sad_pkg::ZONE_NONE;
            sel_valid <= 1'b0;
            sel_write <= 1'b0;
            sel_addr <= 24'h000000;
            reserved_hit <= 1'b0;
        end else if (ce) begin
            sel <= next_sel;
            zone <= next_zone;
            sel_valid <= next_sel_valid;
            sel_write <= next_sel_write;
            sel_addr <= next_sel_addr;
            reserved_hit <= next_reserved_hit;
        end
    end

endmodule : sad_decoder

// ### sad_decoder_monitor.sv
`timescale 1ns/1ps
// Checks each decode result one clock edge after the request that caused it.
module sad_decoder_monitor (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Request and decode result.
    input sad_pkg::sad_req_s req,
    input sad_pkg::sad_sel_s sel,
    input sad_pkg::sad_zone_e zone,
    input wire logic sel_valid,
    input wire logic reserved_hit,
    input wire logic mode_valid,
    input wire logic development_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted request; requests before the mode is known are dropped, so they are left out.
    wire logic acc = ce && req.valid && mode_valid;
    wire logic [23:0] a = req.addr;
    property p_pflash;
        acc && a <= 24'h03ffff && !development_mode |=> sel.prog_flash && zone == sad_pkg::ZONE_STATIC0;
    endproperty
    a_pflash: assert property (p_pflash) else $error("program flash not selected");
    property p_dflash;
        acc && a inside {[24'h0e0000:24'h0e1fff]} && !development_mode |=> sel.data_flash;
    endproperty
    a_dflash: assert property (p_dflash) else $error("data flash not selected");
    property p_dev;
        acc && a <= 24'h03ffff && development_mode |=> sel.ext_zone0 && !sel.prog_flash;
    endproperty
    a_dev: assert property (p_dev) else $error("zone 0 not external in development mode");
    property p_sram;
        acc && a inside {[24'h0ec000:24'h0ee7ff]} |=> sel.system_ram && zone == sad_pkg::ZONE_NONE;
    endproperty
    a_sram: assert property (p_sram) else $error("system ram not selected");
    property p_link;
        acc && a[23:7] == 17'h1de3 |=> sel.link_regs;
    endproperty
    a_link: assert property (p_link) else $error("link registers not selected");
    property p_ext1;
        acc && a[23:22] == 2'h1 |=> sel.ext_zone1 && zone == sad_pkg::ZONE_STATIC1;
    endproperty
    a_ext1: assert property (p_ext1) else $error("external zone 1 wrong");
    property p_ext2;
        acc && a[23] && a[23:16] != 8'hff |=> sel.ext_zone2 && zone == sad_pkg::ZONE_STATIC2;
    endproperty
    a_ext2: assert property (p_ext2) else $error("external zone 2 wrong");
    property p_io;
        acc && a[23:8] == 16'hfffb |=> sel.io_zone && zone == sad_pkg::ZONE_IO;
    endproperty
    a_io: assert property (p_io) else $error("io zone wrong");
    property p_resv;
        acc && a inside {[24'h040000:24'h0dffff]} |=> reserved_hit && sel == '0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved address selected a region");
    property p_one;
        sel_valid && !reserved_hit |-> $onehot(sel);
    endproperty
    a_one: assert property (p_one) else $error("select not one-hot");
    c_dev: cover property (acc && development_mode);
    c_resv: cover property (reserved_hit);
    c_b2b: cover property (acc ##1 acc);
endmodule : sad_decoder_monitor

// ### sad_core_model.sv
`timescale 1ns/1ps
// Core bus model: one request per call, launched just after a rising edge.
module sad_core_model (
    // Clock.
    input wire logic clk,
    // Request to the decoder.
    output sad_pkg::sad_req_s req
);
    initial req = '0;
    // Idle cycles invert the address so a stale value never looks like a held one.
    task automatic go(input logic v, input logic w, input logic [23:0] a);
        @(posedge clk);
        #1;
        req.valid = v;
        req.write = w;
        req.addr = v ? a : ~req.addr;
    endtask : go
endmodule : sad_core_model

// ### system_address_decoder_bench.sv
`timescale 1ns/1ps
// Drives the decoder through the core bus model and compares every decode.
module system_address_decoder_bench;
    logic clk, rst, ce, flash_empty, sel_valid, sel_write, reserved_hit, mode_valid, development_mode;
    logic [2:0] environment_select_pins;
    logic [23:0] sel_addr;
    sad_pkg::sad_req_s req;
    sad_pkg::sad_sel_s sel;
    sad_pkg::sad_zone_e zone;
    sad_pkg::sad_mode_e mode;
    int err_total, cmp_count, cyc;
    // Rows: address, expected one-hot select, expected zone.
    logic [38:0] rows [21] = '{{24'h03ffff, 12'h800, 3'h1}, {24'h0e1fff, 12'h400, 3'h1}, {24'h0e91ff, 12'h200, 3'h0},
        {24'h0ec000, 12'h100, 3'h0}, {24'h0eebff, 12'h080, 3'h0}, {24'h0ef180, 12'h040, 3'h0},
        {24'h400000, 12'h010, 3'h2}, {24'h7fffff, 12'h010, 3'h2}, {24'h800000, 12'h008, 3'h3},
        {24'hfeffff, 12'h008, 3'h3}, {24'hff0000, 12'h004, 3'h0}, {24'hfffaff, 12'h004, 3'h0},
        {24'hfffb00, 12'h002, 3'h4}, {24'hfffc00, 12'h001, 3'h0}, {24'hffffff, 12'h001, 3'h0},
        {24'h040000, 12'h000, 3'h0}, {24'h0e2000, 12'h000, 3'h0}, {24'h0e9200, 12'h000, 3'h0},
        {24'h0ef17f, 12'h000, 3'h0}, {24'h0ef200, 12'h000, 3'h0}, {24'h3fffff, 12'h000, 3'h0}};
    // Rows: pins, empty flag, expected mode; the last one leaves development mode set.
    logic [5:0] modes [6] = '{{3'h7, 1'b1, 2'h3}, {3'h3, 1'b0, 2'h1}, {3'h6, 1'b0, 2'h3},
        {3'h3, 1'b1, 2'h3}, {3'h7, 1'b0, 2'h0}, {3'h0, 1'b0, 2'h2}};
    sad_decoder i_sad_decoder (.clk, .rst, .ce, .environment_select_pins, .flash_empty, .req, .sel, .zone,
        .sel_valid, .sel_write, .sel_addr, .reserved_hit, .mode, .mode_valid, .development_mode);
    sad_core_model i_sad_core_model (.clk, .req);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // Reset with the given straps; a request before the mode is known must be dropped.
    task automatic do_reset(input logic [2:0] e, input logic f, input logic [1:0] m);
        int n;
        rst = 1'b1;
        environment_select_pins = e;
        flash_empty = f;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        i_sad_core_model.go(1'b1, 1'b0, 24'h0e8000);
        i_sad_core_model.go(1'b0, 1'b0, 24'h0);
        chk(sel_valid, 1'b0);
        n = 0;
        while (mode_valid !== 1'b1 && n < 10) begin
            i_sad_core_model.go(1'b0, 1'b0, 24'h0);
            n++;
        end
        chk(mode, m);
    endtask : do_reset
    task automatic check_row(input int j);
        chk(sel, rows[j][14:3]);
        chk(zone, rows[j][2:0]);
        chk(reserved_hit, rows[j][14:3] == 12'h0);
        chk(sel_addr, rows[j][38:15]);
        chk(sel_write, j[0]);
    endtask : check_row
    // Hang guard: the whole run needs about a hundred cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        environment_select_pins = 3'h7;
        flash_empty = 1'b0;
        for (int k = 0; k < 6; k++) do_reset(modes[k][5:3], modes[k][2], modes[k][1:0]);
        $display("mode table done");
        // Both flash regions go to the external zone-0 select in development mode.
        i_sad_core_model.go(1'b1, 1'b0, 24'h000100);
        i_sad_core_model.go(1'b1, 1'b1, 24'h0e0000);
        chk(sel, 12'h020);
        chk(zone, 3'h1);
        i_sad_core_model.go(1'b0, 1'b0, 24'h0);
        chk(sel, 12'h020);
        chk(sel_write, 1'b1);
        $display("development mode done");
        do_reset(3'h7, 1'b0, 2'h0);
        // Requests go back to back, so each result is checked while the next is in flight.
        for (int i = 0; i < 21; i++) begin
            i_sad_core_model.go(1'b1, i[0], rows[i][38:15]);
            if (i > 0) check_row(i - 1);
        end
        i_sad_core_model.go(1'b0, 1'b0, 24'h0);
        check_row(20);
        $display("address table done");
        // A low enable must freeze the last decode even while a new request is offered.
        i_sad_core_model.go(1'b1, 1'b0, 24'hfffb00);
        @(posedge clk);
        #1;
        ce = 1'b0;
        i_sad_core_model.go(1'b1, 1'b1, 24'h400000);
        chk(sel, 12'h002);
        i_sad_core_model.go(1'b0, 1'b0, 24'h0);
        chk(zone, 3'h4);
        chk(sel_write, 1'b0);
        ce = 1'b1;
        i_sad_core_model.go(1'b1, 1'b0, 24'h800000);
        i_sad_core_model.go(1'b0, 1'b0, 24'h0);
        chk(sel, 12'h008);
        chk(mode_valid, 1'b1);
        $display("enable hold done");
        close_out();
    end
endmodule : system_address_decoder_bench
bind sad_decoder sad_decoder_monitor i_sad_decoder_monitor (.clk, .rst, .ce, .req, .sel, .zone, .sel_valid,
    .reserved_hit, .mode_valid, .development_mode);
